// File: shared/supervisor_params.svh
// Timing constants and reset values of the supply supervisor with watchdog.
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_NS            50

// ****************************************
// Times as specified
// ****************************************
`define RESET_HOLD_PERIOD_MS     200
`define WATCHDOG_TIMEOUT_MS      1600
`define UNDERVOLTAGE_DELAY_NS    20000
`define MANUAL_RESET_NOISE_NS    100

// ****************************************
// Times in clock cycles
// ****************************************
`define RESET_HOLD_CYCLES        ((`RESET_HOLD_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define WATCHDOG_TIMEOUT_CYCLES  ((`WATCHDOG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define UNDERVOLTAGE_CYCLES      (`UNDERVOLTAGE_DELAY_NS / `CLK_PERIOD_NS)
`define MANUAL_RESET_CYCLES      ((`MANUAL_RESET_NOISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)

// ****************************************
// Reset values of the pin synchroniser
// ****************************************
`define PIN_RESET_VALUE          3'h6

`endif

// File: shared/supervisor_pkg.sv
// Types shared by the supply supervisor files.
package supervisor_pkg;

   typedef logic [25:0] cnt_t;

   typedef struct packed {
      logic undervoltage;
      logic manual_reset_n;
      logic strobe;
   } pins_s;

   typedef enum logic [1:0] {
      ST_ASSERT = 2'b00,
      ST_HOLD   = 2'b01,
      ST_RUN    = 2'b10
   } state_e;

endpackage

// File: design/pin_synchroniser.sv
// Three-stage synchroniser for the asynchronous supervisor pins.
`timescale 1ns/100ps
`include "supervisor_params.svh"

module pin_synchroniser (
   input  wire logic                  clk,   // System clock.
   input  wire logic                  rst,   // Synchronous reset, active high.
   input  wire supervisor_pkg::pins_s pins,  // Raw pin levels.
   output supervisor_pkg::pins_s      level  // Agreed levels.
);

   supervisor_pkg::pins_s s1_q;
   supervisor_pkg::pins_s s2_q;
   supervisor_pkg::pins_s s3_q;
   supervisor_pkg::pins_s level_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= `PIN_RESET_VALUE;
         s2_q <= `PIN_RESET_VALUE;
         s3_q <= `PIN_RESET_VALUE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit changes only once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= `PIN_RESET_VALUE;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign level = level_q;

endmodule

// File: design/supply_supervisor_watchdog_reset.sv
// Supply supervisor: undervoltage, manual and watchdog reset timing.
// Behaviour
// RL1: Reset outputs stay asserted while the supply is below its trip level.
// RL2: After supply recovery, reset is held at least 140 ms.
// RL3: Reset hold period lies between 140 and 400 ms, nominally 200 ms.
// RL4: Reset asserts about 20 us after the supply drops below trip.
// RL5: Reset is issued when the strobe does not change before timeout.
// RL6: Watchdog timeout lies between 1.12 s and 3.20 s, nominally 1.60 s.
// RL7: A floating strobe pin is serviced internally, disabling the watchdog.
// RL8: Where manual reset is fitted, driving it low starts a reset.
// RL9: Reset asserts within 5 us of manual reset going low.
// RL10: Manual reset low pulses of about 100 ns or less are ignored.
// RL11: An active-low push-pull reset output is low while reset is active.
// RL12: An active-high reset output is the complement of the active-low one.
// RL13: Watchdog timing starts only once the reset outputs go inactive.
// RL14: Each strobe edge before expiry clears the watchdog and restarts it.
// RL15: Watchdog expiry gives a full hold period, then watchdog timing restarts.
// RL16: The hold period after manual reset starts when the input returns high.
// RL17: All three inputs are synchronised to the clock before use.
// RL18: The processor toggles the strobe well inside the minimum timeout.
`timescale 1ns/100ps
`include "supervisor_params.svh"

module supply_supervisor_watchdog_reset #(
   parameter supervisor_pkg::cnt_t HOLD_CYCLES     = supervisor_pkg::cnt_t'(`RESET_HOLD_CYCLES),
   parameter supervisor_pkg::cnt_t WATCHDOG_CYCLES = supervisor_pkg::cnt_t'(`WATCHDOG_TIMEOUT_CYCLES),
   parameter bit                   MANUAL_PRESENT  = 1'b1
) (
   input  wire logic CLOCK,                 // 20 MHz clock.
   input  wire logic RST,                   // Synchronous reset, active high.
   input  wire logic UNDERVOLTAGE,          // Comparator flag, high when supply is below trip.
   input  wire logic MANUAL_RESET_N_INPUT,  // Manual reset, active low.
   input  wire logic WATCHDOG_STROBE_INPUT, // Watchdog strobe from the processor.
   output logic      RESET_N,               // Reset output, active low.
   output logic      RESET,                 // Reset output, active high.
   output logic      WATCHDOG_PULL_HIGH     // Weak pull level for the strobe pin.
);

   localparam supervisor_pkg::cnt_t UV_CYCLES = supervisor_pkg::cnt_t'(`UNDERVOLTAGE_CYCLES);
   localparam supervisor_pkg::cnt_t MR_CYCLES = supervisor_pkg::cnt_t'(`MANUAL_RESET_CYCLES);
   localparam supervisor_pkg::cnt_t PULL_FROM = supervisor_pkg::cnt_t'(WATCHDOG_CYCLES
                                                - (WATCHDOG_CYCLES >> 3));

   // Saturating filter step: counts while the condition holds, clears otherwise.
   function automatic supervisor_pkg::cnt_t filter_step(input logic cond,
                                                         input supervisor_pkg::cnt_t cnt,
                                                         input supervisor_pkg::cnt_t limit);
      if (!cond) begin
         filter_step = '0;
      end else if (cnt < limit) begin
         filter_step = cnt + 26'h0000001;
      end else begin
         filter_step = cnt;
      end
   endfunction

   supervisor_pkg::pins_s  raw;
   supervisor_pkg::pins_s  lvl;
   supervisor_pkg::state_e state_q;
   supervisor_pkg::cnt_t   uv_cnt_q;
   supervisor_pkg::cnt_t   mr_cnt_q;
   supervisor_pkg::cnt_t   hold_cnt_q;
   supervisor_pkg::cnt_t   wd_cnt_q;
   logic                   strobe_prev_q;
   logic                   uv_active;
   logic                   mr_active;
   logic                   strobe_edge;

   // ****************************************
   // Input synchronisation
   // ****************************************
   assign raw.undervoltage   = UNDERVOLTAGE;
   assign raw.manual_reset_n = MANUAL_RESET_N_INPUT;
   assign raw.strobe         = WATCHDOG_STROBE_INPUT;

   pin_synchroniser u_sync ( // RL17
      .clk   (CLOCK),
      .rst   (RST),
      .pins  (raw),
      .level (lvl)
   );

   // ****************************************
   // Undervoltage and manual reset filters
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         uv_cnt_q <= UV_CYCLES;
      end else begin
         uv_cnt_q <= filter_step(lvl.undervoltage, uv_cnt_q, UV_CYCLES); // RL4
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         mr_cnt_q <= '0;
      end else begin
         mr_cnt_q <= filter_step(MANUAL_PRESENT && !lvl.manual_reset_n, mr_cnt_q, MR_CYCLES); // RL10
      end
   end

   assign uv_active = lvl.undervoltage && (uv_cnt_q >= UV_CYCLES);  // RL4
   assign mr_active = !lvl.manual_reset_n && (mr_cnt_q >= MR_CYCLES); // RL8 RL9

   // ****************************************
   // Strobe edge detection
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         strobe_prev_q <= 1'b0;
      end else begin
         strobe_prev_q <= lvl.strobe;
      end
   end

   assign strobe_edge = lvl.strobe ^ strobe_prev_q; // RL14

   // ****************************************
   // Reset sequencing
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_q <= supervisor_pkg::ST_ASSERT;
      end else if (uv_active || mr_active) begin
         state_q <= supervisor_pkg::ST_ASSERT; // RL1 RL8
      end else begin
         unique case (state_q)
            supervisor_pkg::ST_ASSERT: begin
               state_q <= supervisor_pkg::ST_HOLD; // RL2 RL16
            end
            supervisor_pkg::ST_HOLD: begin
               if (hold_cnt_q >= HOLD_CYCLES - 26'h0000001) begin
                  state_q <= supervisor_pkg::ST_RUN; // RL3 RL13
               end
            end
            supervisor_pkg::ST_RUN: begin
               if (!strobe_edge && wd_cnt_q >= WATCHDOG_CYCLES - 26'h0000001) begin
                  state_q <= supervisor_pkg::ST_HOLD; // RL5 RL6 RL15
               end
            end
            default: begin
               state_q <= supervisor_pkg::ST_ASSERT;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST || state_q != supervisor_pkg::ST_HOLD) begin
         hold_cnt_q <= '0; // RL16
      end else begin
         hold_cnt_q <= hold_cnt_q + 26'h0000001; // RL3
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST || state_q != supervisor_pkg::ST_RUN || strobe_edge) begin
         wd_cnt_q <= '0; // RL13 RL14 RL15
      end else begin
         wd_cnt_q <= wd_cnt_q + 26'h0000001; // RL6
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RESET_N <= 1'b0;
         RESET   <= 1'b1;
      end else begin
         RESET_N <= (state_q == supervisor_pkg::ST_RUN);  // RL11
         RESET   <= (state_q != supervisor_pkg::ST_RUN);  // RL12
      end
   end

   // The pin is pulled low for the first seven eighths of the period and high for the rest.
   // An open pin follows the pull, so its own edges keep restarting the watchdog.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         WATCHDOG_PULL_HIGH <= 1'b0;
      end else begin
         WATCHDOG_PULL_HIGH <= (state_q == supervisor_pkg::ST_RUN) && (wd_cnt_q >= PULL_FROM); // RL7
      end
   end

endmodule

// File: verification/supervisor_properties.sv
// Port-level assertions for the supply supervisor.
`timescale 1ns/100ps
module supervisor_properties #(
   parameter supervisor_pkg::cnt_t HOLD_CYCLES     = 26'h00c8,
   parameter supervisor_pkg::cnt_t WATCHDOG_CYCLES = 26'h0320
) (
   input wire logic CLOCK,                 // Clock.
   input wire logic RST,                   // Reset.
   input wire logic UNDERVOLTAGE,          // Low supply.
   input wire logic MANUAL_RESET_N_INPUT,  // Button.
   input wire logic WATCHDOG_STROBE_INPUT, // Strobe pin.
   input wire logic RESET_N,               // Reset out.
   input wire logic RESET,                 // Reset out.
   input wire logic WATCHDOG_PULL_HIGH     // Pin pull.
);
   localparam int PULL_AT = int'(WATCHDOG_CYCLES - WATCHDOG_CYCLES / 8);
   int   uvh_q, uvl_q, mrh_q, wd_q;
   logic stb_q;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   always_ff @(posedge CLOCK) uvh_q <= UNDERVOLTAGE ? uvh_q + 1 : 0;
   always_ff @(posedge CLOCK) uvl_q <= UNDERVOLTAGE ? 0 : uvl_q + 1;
   always_ff @(posedge CLOCK) mrh_q <= MANUAL_RESET_N_INPUT ? mrh_q + 1 : 0;
   always_ff @(posedge CLOCK) stb_q <= WATCHDOG_STROBE_INPUT;
   always_ff @(posedge CLOCK) wd_q <= (!RESET_N || stb_q != WATCHDOG_STROBE_INPUT) ? 0 : wd_q + 1;
   sequence s_press; $fell(MANUAL_RESET_N_INPUT) ##1 !MANUAL_RESET_N_INPUT[*4]; endsequence
   sequence s_glitch; RESET_N && $fell(MANUAL_RESET_N_INPUT) ##1 MANUAL_RESET_N_INPUT; endsequence
   property p_compl; RESET == !RESET_N; endproperty
   property p_uv_keep; uvh_q >= 420 |-> !RESET_N; endproperty
   property p_uv_rel; $rose(RESET_N) |-> uvl_q >= HOLD_CYCLES; endproperty
   property p_mr_rel; $rose(RESET_N) |-> mrh_q >= HOLD_CYCLES; endproperty
   property p_mr_delay; s_press |-> ##[0:95] !RESET_N; endproperty
   property p_mr_noise; s_glitch |=> RESET_N[*8]; endproperty
   property p_wd_max; wd_q <= WATCHDOG_CYCLES + 12; endproperty
   property p_wd_min; $fell(RESET_N) && uvh_q == 0 && mrh_q > 20 |-> wd_q >= WATCHDOG_CYCLES - 10; endproperty
   property p_pull; $rose(WATCHDOG_PULL_HIGH) |-> wd_q >= PULL_AT - 3 && wd_q <= PULL_AT + 10; endproperty
   a_compl: assert property (p_compl) else $error("Outputs not complementary.");
   a_uv_keep: assert property (p_uv_keep) else $error("Released in low supply.");
   a_uv_rel: assert property (p_uv_rel) else $error("Supply hold too short.");
   a_mr_rel: assert property (p_mr_rel) else $error("Button hold too short.");
   a_mr_delay: assert property (p_mr_delay) else $error("Button reset late.");
   a_mr_noise: assert property (p_mr_noise) else $error("Glitch gave reset.");
   a_wd_max: assert property (p_wd_max) else $error("Watchdog missed expiry.");
   a_wd_min: assert property (p_wd_min) else $error("Watchdog fired early.");
   a_pull: assert property (p_pull) else $error("Pin pull at wrong time.");
endmodule
bind supply_supervisor_watchdog_reset supervisor_properties #(
   .HOLD_CYCLES(HOLD_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES)
) checker_inst (.CLOCK(CLOCK), .RST(RST), .UNDERVOLTAGE(UNDERVOLTAGE), .MANUAL_RESET_N_INPUT(MANUAL_RESET_N_INPUT),
   .WATCHDOG_STROBE_INPUT(WATCHDOG_STROBE_INPUT), .RESET_N(RESET_N), .RESET(RESET),
   .WATCHDOG_PULL_HIGH(WATCHDOG_PULL_HIGH));

// File: verification/processor_model.sv
// Processor model that strobes the watchdog pin or leaves it open.
`timescale 1ns/100ps
module processor_model #(
   parameter int GAP = 100
) (
   input  wire logic clk,       // Clock.
   input  wire logic reset_n,   // Reset in.
   input  wire logic drive,     // Output enabled.
   input  wire logic run,       // Software strobing.
   input  wire logic pull_high, // Pin pull.
   output logic      pin        // Pin level.
);
   int   gap_q = 0;
   logic stb_q = 1'b0;
   always_ff @(posedge clk) begin
      if (reset_n && run) begin
         gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
         if (gap_q == GAP - 1) stb_q <= !stb_q;
      end
   end
   // An open pin settles to the supervisor's weak pull.
   assign pin = drive ? stb_q : pull_high;
endmodule

// File: verification/test_supply_supervisor_watchdog_reset.sv
// Self-checking bench for the supply supervisor.
`timescale 1ns/100ps
module test_supply_supervisor_watchdog_reset;
   localparam int HOLD = 200;
   localparam int WD   = 800;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       uv = 1'b0;
   logic       mr_n = 1'b1;
   logic       drive = 1'b1;
   logic       run = 1'b1;
   logic       pin, reset_n, reset, pull_high;
   logic [7:0] lfsr_q = 8'h2f;
   bit         pulled = 1'b0;
   int         failures = 0;
   int         n_tests = 0;
   int         n;
   supply_supervisor_watchdog_reset #(.HOLD_CYCLES(supervisor_pkg::cnt_t'(HOLD)),
      .WATCHDOG_CYCLES(supervisor_pkg::cnt_t'(WD)), .MANUAL_PRESENT(1'b1)) DUT (.CLOCK(clock), .RST(rst),
      .UNDERVOLTAGE(uv), .MANUAL_RESET_N_INPUT(mr_n), .WATCHDOG_STROBE_INPUT(pin), .RESET_N(reset_n),
      .RESET(reset), .WATCHDOG_PULL_HIGH(pull_high));
   processor_model proc (.clk(clock), .reset_n(reset_n), .drive(drive), .run(run), .pull_high(pull_high),
      .pin(pin));
   initial forever #25 clock = ~clock;
   // The pull is only counted while the pin is open, so earlier watchdog expiries cannot satisfy the check.
   always @(posedge clock) begin
      if (drive) pulled = 1'b0;
      else if (pull_high === 1'b1) pulled = 1'b1;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #5;
   endtask
   task automatic check(input string what, input int lo, input int hi, input int got);
      n_tests++;
      if (got < lo || got > hi) begin
         failures++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wait_out(input logic v, input int limit, output int k);
      k = 0;
      while (reset_n !== v && k < limit) begin
         step(1);
         k++;
      end
      check("complement", 1, 1, int'(reset === ~reset_n));
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      failures++;
      stop_test();
   end
   initial begin
      step(6);
      rst = 1'b0;
      wait_out(1'b1, HOLD + 40, n);
      check("power-up hold", HOLD, HOLD + 20, n);
      $display("Test power-up done");
      wait_out(1'b0, 3000, n);
      check("strobed run", 3000, 3000, n);
      $display("Test strobing done");
      run = 1'b0;
      wait_out(1'b0, WD + 40, n);
      check("first expiry", WD - 100, WD + 12, n);
      for (int i = 0; i < 2; i++) begin
         wait_out(1'b1, HOLD + 40, n);
         check("expiry hold", HOLD, HOLD + 10, n);
         wait_out(1'b0, WD + 40, n);
         check("restart expiry", WD, WD + 10, n);
      end
      run = 1'b1;
      wait_out(1'b1, HOLD + 40, n);
      $display("Test watchdog done");
      drive = 1'b0;
      wait_out(1'b0, 4 * WD, n);
      check("open pin", 4 * WD, 4 * WD, n);
      check("pull seen", 1, 1, int'(pulled));
      drive = 1'b1;
      $display("Test open pin done");
      repeat (4) begin
         lfsr_q = lfsr(lfsr_q);
         mr_n = 1'b0;
         step(1 + int'(lfsr_q[0]));
         mr_n = 1'b1;
         step(20);
      end
      check("glitch", 1, 1, int'(reset_n === 1'b1));
      mr_n = 1'b0;
      wait_out(1'b0, 100, n);
      check("press delay", 1, 99, n);
      step(5 + int'(lfsr_q[3:0]));
      mr_n = 1'b1;
      wait_out(1'b1, HOLD + 40, n);
      check("release hold", HOLD, HOLD + 12, n);
      $display("Test manual done");
      lfsr_q = lfsr(lfsr_q);
      uv = 1'b1;
      step(100 + int'(lfsr_q));
      uv = 1'b0;
      step(10);
      check("short dip", 1, 1, int'(reset_n === 1'b1));
      uv = 1'b1;
      wait_out(1'b0, 500, n);
      check("dip delay", 400, 415, n);
      step(300);
      check("held low", 1, 1, int'(reset_n === 1'b0));
      uv = 1'b0;
      wait_out(1'b1, HOLD + 40, n);
      check("recovery hold", HOLD, HOLD + 12, n);
      $display("Test supply done");
      stop_test();
   end
endmodule
